// [rtl/mso_move_stretch.sv]
// minimum on-time stretcher for the move output
`timescale 1ns/1ps
module mso_move_stretch
  import mso_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // control
  input wire logic moving,
  input wire logic [7:0] min_ms,
  // result
  output logic move_out
);
  logic [DIV_W-1:0] div_ff, nxt_div; // millisecond divider
  logic tick_ff, nxt_tick; // one-cycle millisecond pulse
  logic [7:0] cnt_ff, nxt_cnt; // elapsed ms since motion start
  mso_move_st_t st_ff, nxt_st; // stretch state
  logic move_ff, nxt_move; // registered output

  // =====================================================================
  // next-state logic
  always_comb begin
    nxt_div = div_ff + 1'b1;
    nxt_tick = 1'b0;
    if (div_ff == DIV_LAST) begin
      nxt_div = '0;
      nxt_tick = 1'b1;
    end
    nxt_cnt = cnt_ff;
    nxt_st = st_ff;
    if (tick_ff && cnt_ff != 8'hFF) begin
      nxt_cnt = cnt_ff + 1'b1;
    end
    case (st_ff)
      MSO_ST_IDLE: begin
        // motion start restarts the minimum window
        if (moving) begin
          nxt_st = MSO_ST_RUN;
          nxt_cnt = '0;
        end
      end
      MSO_ST_RUN: begin
        // motion ended early holds the output
        if (!moving) begin
          nxt_st = (cnt_ff < min_ms) ? MSO_ST_HOLD : MSO_ST_IDLE;
        end
      end
      MSO_ST_HOLD: begin
        if (moving) begin
          nxt_st = MSO_ST_RUN;
        end else if (cnt_ff >= min_ms) begin
          nxt_st = MSO_ST_IDLE;
        end
      end
      default: nxt_st = MSO_ST_IDLE;
    endcase
    nxt_move = (nxt_st != MSO_ST_IDLE);
  end

  // registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
      cnt_ff <= '0;
      st_ff <= MSO_ST_IDLE;
      move_ff <= 1'b0;
    end else begin
      div_ff <= nxt_div;
      tick_ff <= nxt_tick;
      cnt_ff <= nxt_cnt;
      st_ff <= nxt_st;
      move_ff <= nxt_move;
    end
  end

  assign move_out = move_ff;
endmodule

// [rtl/mso_top.sv]
// motion status outputs: ready, move, busy, in-position, cutback, torque, speed
`timescale 1ns/1ps
module mso_top
  import mso_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // readiness gating inputs
  input wire mso_ready_in_t rdy_in,
  // parameter settings
  input wire mso_cfg_t cfg,
  // motion state
  input wire mso_motion_t mot,
  // status outputs
  output logic ready,
  output logic move_active,
  output logic profile_busy,
  output logic in_position,
  output logic cutback_reached,
  output logic torque_limit_reached,
  output logic speed_attained
);
  logic ready_ff, nxt_ready; // readiness
  logic busy_ff, nxt_busy; // profile generation busy
  logic inpos_ff, nxt_inpos; // in-position
  logic cut_ff, nxt_cut; // cutback reached
  logic tlc_ff, nxt_tlc; // torque limit reached
  logic va_ff, nxt_va; // speed attained
  logic inpos_arm_ff, nxt_inpos_arm; // positioning finished normally
  logic signed [POS_W+1:0] dev_ext; // deviation minus offset
  logic [POS_W+1:0] dev_abs; // magnitude from shifted centre
  logic [POS_W-1:0] pos_abs; // raw deviation magnitude
  logic [7:0] range_lim; // clamped window width
  logic signed [7:0] ofs_lim; // clamped window offset
  logic [7:0] band_lim; // clamped speed band
  logic dev_over; // deviation beyond 1.8 degrees
  logic servo_mode; // servo emulation selected
  logic fb_in_band; // detected near command speed
  logic tgt_in_band; // detected near target speed
  logic cmd_match; // command speed at target
  logic move_w; // stretched move from leaf

  // =====================================================================
  // move output with minimum on-time
  mso_move_stretch u_stretch (
    .clock(clock),
    .nrst(nrst),
    .moving(mot.motor_moving),
    .min_ms(cfg.move_min_ms),
    .move_out(move_w)
  );

  // =====================================================================
  // speed band check helper
  function automatic logic in_band(input logic signed [SPD_W-1:0] a,
                                   input logic signed [SPD_W-1:0] b,
                                   input logic [7:0] band);
    logic signed [SPD_W:0] d;
    logic [SPD_W:0] m;
    d = {a[SPD_W-1], a} - {b[SPD_W-1], b};
    m = d[SPD_W] ? (SPD_W+1)'(-d) : d;
    in_band = (m <= {{(SPD_W-7){1'b0}}, band});
  endfunction

  // =====================================================================
  // combinational helpers: clamps, deviations, bands
  always_comb begin
    range_lim = (cfg.inpos_range > INPOS_RANGE_MAX) ? INPOS_RANGE_MAX : cfg.inpos_range;
    ofs_lim = cfg.inpos_offset;
    if (cfg.inpos_offset > INPOS_OFS_MAX) begin
      ofs_lim = INPOS_OFS_MAX;
    end else if (cfg.inpos_offset < -INPOS_OFS_MAX) begin
      ofs_lim = -INPOS_OFS_MAX;
    end
    band_lim = cfg.va_band;
    if (cfg.va_band < VA_BAND_MIN) begin
      band_lim = VA_BAND_MIN;
    end else if (cfg.va_band > VA_BAND_MAX) begin
      band_lim = VA_BAND_MAX;
    end
    // window centre shifted by the offset
    dev_ext = {{2{mot.pos_deviation[POS_W-1]}}, mot.pos_deviation}
              - {{(POS_W-6){ofs_lim[7]}}, ofs_lim};
    dev_abs = dev_ext[POS_W+1] ? (POS_W+2)'(-dev_ext) : dev_ext;
    pos_abs = mot.pos_deviation[POS_W-1] ? POS_W'(-mot.pos_deviation)
                                         : mot.pos_deviation;
    dev_over = (pos_abs > TLC_DEV_LIMIT);
    servo_mode = mot.current_mode_select;
    fb_in_band = in_band(mot.detected_speed, mot.command_speed, band_lim);
    tgt_in_band = in_band(mot.detected_speed, mot.target_speed, band_lim);
    cmd_match = (mot.command_speed == mot.target_speed);
  end

  // =====================================================================
  // readiness next value
  always_comb begin
    nxt_ready = rdy_in.ctrl_power_on && rdy_in.main_power_on
             && !rdy_in.start_any && !rdy_in.free_in && !rdy_in.stop_in
             && !rdy_in.soft_stop_current_off && !rdy_in.pause_in
             && !rdy_in.deviation_clear_input;
    // alarm and motion block readiness
    if (rdy_in.alarm_active || mot.motor_moving) begin
      nxt_ready = 1'b0;
    end
    // tool jobs and serial maintenance block readiness
    if (rdy_in.tool_busy || rdy_in.serial_job_busy) begin
      nxt_ready = 1'b0;
    end
    // excitation enable only counts when assigned
    if (rdy_in.excite_assigned && !rdy_in.excite_enable) begin
      nxt_ready = 1'b0;
    end
  end

  // =====================================================================
  // profile busy and in-position next values
  always_comb begin
    nxt_busy = mot.internal_profile;
    nxt_inpos_arm = inpos_arm_ff;
    // arm on normal finish, disarm on new motion or interruption
    if (mot.motor_moving) begin
      nxt_inpos_arm = 1'b0;
    end else if (mot.stop_interrupted || mot.continuous_stop) begin
      nxt_inpos_arm = 1'b0;
    end else if (mot.positioning_done) begin
      nxt_inpos_arm = 1'b1;
    end
    nxt_inpos = nxt_inpos_arm && !mot.motor_moving
             && (dev_abs <= {{(POS_W-6){1'b0}}, range_lim});
  end

  // =====================================================================
  // cutback and torque-limit next values
  always_comb begin
    nxt_cut = cfg.cutback_enable && mot.cutback_active
           && mot.current_at_standstill;
    nxt_tlc = mot.torque_over_rating
           || (mot.push_motion && mot.push_torque_reached);
    if (!servo_mode) begin
      nxt_tlc = nxt_tlc || dev_over;
    end else if (cfg.sve_ratio == SVE_RATIO_ZERO) begin
      nxt_tlc = nxt_tlc || dev_over;
    end else if (cfg.sve_ratio >= SVE_RATIO_FULL) begin
      nxt_tlc = nxt_tlc || mot.current_at_limit;
    end else begin
      nxt_tlc = nxt_tlc || (dev_over && mot.current_at_limit);
    end
  end

  // =====================================================================
  // speed attained next value
  always_comb begin
    nxt_va = 1'b0;
    if (mot.pulse_input_op) begin
      nxt_va = fb_in_band;
    end else begin
      case (cfg.va_mode)
        MSO_VA_FEEDBACK: nxt_va = fb_in_band;
        MSO_VA_COMMAND: nxt_va = cmd_match;
        MSO_VA_BOTH: nxt_va = tgt_in_band;
        default: nxt_va = fb_in_band;
      endcase
    end
    // only judged while moving
    if (!mot.motor_moving) begin
      nxt_va = 1'b0;
    end
  end

  // =====================================================================
  // status registers
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ready_ff <= 1'b0;
      busy_ff <= 1'b0;
      inpos_ff <= 1'b0;
      cut_ff <= 1'b0;
      tlc_ff <= 1'b0;
      va_ff <= 1'b0;
      inpos_arm_ff <= 1'b0;
    end else begin
      ready_ff <= nxt_ready;
      busy_ff <= nxt_busy;
      inpos_ff <= nxt_inpos;
      cut_ff <= nxt_cut;
      tlc_ff <= nxt_tlc;
      va_ff <= nxt_va;
      inpos_arm_ff <= nxt_inpos_arm;
    end
  end

  // outputs straight from flip-flops
  assign ready = ready_ff;
  assign move_active = move_w;
  assign profile_busy = busy_ff;
  assign in_position = inpos_ff;
  assign cutback_reached = cut_ff;
  assign torque_limit_reached = tlc_ff;
  assign speed_attained = va_ff;
endmodule

// [shared/mso_pkg.sv]
// constants and carrier types for the motion status output block
// =====================================================================
// Functional notes
// - ready needs power, no start, no stops
// - ready also needs no alarm, no motion
// - ready low during tool or serial jobs
// - excitation enable blocks ready only if assigned
// - move output high while motor operates
// - move stays high programmable minimum milliseconds
// - profile busy during internally generated operations
// - in position after positioning settles in window
// - window width 0 to 180 tenths, default 18
// - window centre offset within plus minus 18
// - no in position after stopped or interrupted
// - cutback reached when current hits standstill value
// - cutback disabled means never cutback reached
// - torque limit over rating or push limit
// - alpha mode: deviation above 1.8 degrees
// - servo emulation ratio selects torque limit condition
// - speed attained judged by selected mode (pulse input operation always uses feedback)
// - feedback mode: detected speed within band
// - command mode: command speed equals target
// - mode 0 feedback, 1 command, 2 both
// - tolerance band 1 to 200 rpm, default 30
// - combined mode: detected speed near target
// - mode input low alpha, high servo emulation
package mso_pkg;
  // =====================================================================
  // timing
  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MS_TICK_HZ = 1_000;
  localparam int unsigned MS_CYCLES = CLK_HZ / MS_TICK_HZ;
  localparam int unsigned DIV_W = 18;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(MS_CYCLES - 1);
  // =====================================================================
  // settings, widths, limits and defaults
  localparam int unsigned POS_W = 16;
  localparam int unsigned SPD_W = 16;
  localparam logic [7:0] MOVE_MIN_DEF = 8'h00;
  localparam logic [7:0] INPOS_RANGE_MAX = 8'hB4;
  localparam logic [7:0] INPOS_RANGE_DEF = 8'h12;
  localparam logic signed [7:0] INPOS_OFS_MAX = 8'sh12;
  localparam logic signed [7:0] INPOS_OFS_DEF = 8'sh00;
  localparam logic [POS_W-1:0] TLC_DEV_LIMIT = 16'h0012;
  localparam logic [7:0] SVE_RATIO_FULL = 8'h64;
  localparam logic [7:0] SVE_RATIO_ZERO = 8'h00;
  localparam logic [7:0] VA_BAND_MIN = 8'h01;
  localparam logic [7:0] VA_BAND_MAX = 8'hC8;
  localparam logic [7:0] VA_BAND_DEF = 8'h1E;
  // =====================================================================
  // speed attainment modes
  typedef enum logic [1:0] {
    MSO_VA_FEEDBACK = 2'h0,
    MSO_VA_COMMAND = 2'h1,
    MSO_VA_BOTH = 2'h2
  } mso_va_mode_t;
  // move stretch states
  typedef enum logic [2:0] {
    MSO_ST_IDLE = 3'h1,
    MSO_ST_RUN = 3'h2,
    MSO_ST_HOLD = 3'h4
  } mso_move_st_t;
  // =====================================================================
  // readiness gating inputs
  typedef struct packed {
    logic ctrl_power_on;
    logic main_power_on;
    logic start_any;
    logic free_in;
    logic excite_enable;
    logic excite_assigned;
    logic stop_in;
    logic soft_stop_current_off;
    logic pause_in;
    logic deviation_clear_input;
    logic alarm_active;
    logic tool_busy;
    logic serial_job_busy;
  } mso_ready_in_t;
  // parameter settings
  typedef struct packed {
    logic [7:0] move_min_ms;
    logic [7:0] inpos_range;
    logic signed [7:0] inpos_offset;
    logic cutback_enable;
    logic [7:0] sve_ratio;
    logic [1:0] va_mode;
    logic [7:0] va_band;
  } mso_cfg_t;
  // motion state
  typedef struct packed {
    logic motor_moving;
    logic internal_profile;
    logic positioning_done;
    logic stop_interrupted;
    logic continuous_stop;
    logic pulse_input_op;
    logic push_motion;
    logic signed [POS_W-1:0] pos_deviation;
    logic current_at_standstill;
    logic cutback_active;
    logic torque_over_rating;
    logic push_torque_reached;
    logic current_at_limit;
    logic current_mode_select;
    logic signed [SPD_W-1:0] detected_speed;
    logic signed [SPD_W-1:0] command_speed;
    logic signed [SPD_W-1:0] target_speed;
  } mso_motion_t;
endpackage

// [tb/mso_host.sv]
// host model: raises a start command only once ready has been seen
`timescale 1ns/1ps
module mso_host (
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // status and request
  input wire logic ready,
  input wire logic go,
  // start command
  output logic start
);
  logic seen_ff; // ready observed while request pending
  // remember ready before starting, forget when request drops
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      seen_ff <= 1'b0;
    end else begin
      seen_ff <= go & (seen_ff | ready);
    end
  end
  assign start = go & seen_ff;
endmodule

// [tb/mso_top_sva.sv]
// assertion checker for the motion status outputs
`timescale 1ns/1ps
module mso_top_sva
  import mso_pkg::*;
(
  // clock and reset
  input wire logic clock,
  input wire logic nrst,
  // watched inputs
  input wire mso_ready_in_t rdy_in,
  input wire mso_cfg_t cfg,
  input wire mso_motion_t mot,
  // watched outputs
  input wire logic ready,
  input wire logic move_active,
  input wire logic profile_busy,
  input wire logic in_position,
  input wire logic cutback_reached,
  input wire logic torque_limit_reached,
  input wire logic speed_attained
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  // ==========
  // expected conditions worked out from the present inputs
  logic rdy_ok; // all readiness gates open
  logic big; // deviation beyond 1.8 degrees
  logic tlc_exp; // torque limit condition
  logic win_ok; // deviation inside shifted window
  // combinational reference terms
  always_comb begin
    int d;
    int v;
    v = int'(mot.pos_deviation);
    d = v - int'(cfg.inpos_offset);
    win_ok = ((d < 0) ? -d : d) <= int'(cfg.inpos_range);
    big = (v > int'(TLC_DEV_LIMIT)) || (v < -int'(TLC_DEV_LIMIT));
    rdy_ok = rdy_in.ctrl_power_on & rdy_in.main_power_on & !rdy_in.start_any & !rdy_in.free_in
      & (rdy_in.excite_enable | !rdy_in.excite_assigned) & !rdy_in.stop_in
      & !rdy_in.soft_stop_current_off & !rdy_in.pause_in & !rdy_in.deviation_clear_input
      & !rdy_in.alarm_active & !rdy_in.tool_busy & !rdy_in.serial_job_busy & !mot.motor_moving;
    if (!mot.current_mode_select) begin
      tlc_exp = big;
    end else if (cfg.sve_ratio == SVE_RATIO_ZERO) begin
      tlc_exp = big;
    end else if (cfg.sve_ratio >= SVE_RATIO_FULL) begin
      tlc_exp = mot.current_at_limit;
    end else begin
      tlc_exp = big & mot.current_at_limit;
    end
    tlc_exp = tlc_exp | mot.torque_over_rating | (mot.push_motion & mot.push_torque_reached);
  end
  // ==========
  // assertions
  // the $past(nrst) guard skips the first edge after release, where outputs still
  // show their reset values while $past sees inputs from inside reset
  a_ready_gates: assert property ($past(nrst) |-> ready == $past(rdy_ok))
    else $error("ready differs from its gating inputs");
  a_move_follows: assert property ($past(mot.motor_moving) |-> move_active)
    else $error("move output low while motor moving");
  a_move_drop: assert property (!$past(mot.motor_moving) && !$past(mot.motor_moving, 2)
    && $past(cfg.move_min_ms) == 8'h00 |-> !move_active)
    else $error("move output held with zero minimum time");
  a_busy_profile: assert property ($past(nrst)
    |-> profile_busy == $past(mot.internal_profile))
    else $error("profile busy does not follow internal profile");
  a_inpos_window: assert property (in_position |-> $past(win_ok))
    else $error("in position outside the window");
  a_cutback_cond: assert property ($past(nrst) |-> cutback_reached
    == $past(cfg.cutback_enable & mot.cutback_active & mot.current_at_standstill))
    else $error("cutback reached wrong");
  a_torque_cond: assert property ($past(nrst)
    |-> torque_limit_reached == $past(tlc_exp))
    else $error("torque limit output wrong");
  a_speed_cmd: assert property ($past(mot.motor_moving && !mot.pulse_input_op
    && cfg.va_mode == MSO_VA_COMMAND) |-> speed_attained
    == $past(mot.command_speed == mot.target_speed))
    else $error("command speed attainment wrong");
  // ==========
  // scenario coverage
  c_inpos: cover property (in_position);
  c_move_hold: cover property (move_active && !mot.motor_moving);
  c_servo_tlc: cover property (torque_limit_reached && mot.current_mode_select);
  c_speed: cover property (speed_attained);
endmodule

bind mso_top mso_top_sva u_mso_top_sva (.clock(clock), .nrst(nrst), .rdy_in(rdy_in),
  .cfg(cfg), .mot(mot), .ready(ready), .move_active(move_active),
  .profile_busy(profile_busy), .in_position(in_position), .cutback_reached(cutback_reached),
  .torque_limit_reached(torque_limit_reached), .speed_attained(speed_attained));

// [tb/mso_top_tb.sv]
// self-checking bench for the motion status outputs
`timescale 1ns/1ps
module mso_top_tb
  import mso_pkg::*;
;
  typedef struct packed {logic [12:0] mask; logic exp;} mso_rrow_t;
  typedef struct packed {logic sel; logic [7:0] ratio; logic [15:0] dev;
    logic lim; logic ovr; logic push; logic exp;} mso_trow_t;
  typedef struct packed {logic [1:0] mode; logic pulse; logic [15:0] det;
    logic [15:0] cmd; logic [15:0] tgt; logic exp;} mso_srow_t;
  localparam logic [12:0] RDY_BASE = 13'h1800; // both supplies on, all else off
  logic clock = 1'b0;
  logic nrst = 1'b0;
  mso_ready_in_t rdy_tb;
  mso_ready_in_t rdy_in;
  mso_cfg_t cfg;
  mso_motion_t mot;
  logic go;
  logic host_start;
  logic ready, move_active, profile_busy, in_position;
  logic cutback_reached, torque_limit_reached, speed_attained;
  int n_mismatch = 0;
  int n_tests = 0;
  int cycles = 0;
  // readiness rows: bits toggled from the base, expected ready
  mso_rrow_t rrows [15] = '{'{13'h0000, 1'b1}, '{13'h1000, 1'b0}, '{13'h0800, 1'b0},
    '{13'h0400, 1'b0}, '{13'h0200, 1'b0}, '{13'h0100, 1'b1}, '{13'h0080, 1'b0},
    '{13'h0180, 1'b1}, '{13'h0040, 1'b0}, '{13'h0020, 1'b0}, '{13'h0010, 1'b0},
    '{13'h0008, 1'b0}, '{13'h0004, 1'b0}, '{13'h0002, 1'b0}, '{13'h0001, 1'b0}};
  // torque rows
  mso_trow_t trows [11] = '{'{1'b0, 8'h00, 16'h0012, 1'b1, 1'b0, 1'b0, 1'b0},
    '{1'b0, 8'h00, 16'h0013, 1'b0, 1'b0, 1'b0, 1'b1}, '{1'b0, 8'h00, 16'hFFED, 1'b0, 1'b0, 1'b0, 1'b1},
    '{1'b1, 8'h00, 16'h0013, 1'b0, 1'b0, 1'b0, 1'b1}, '{1'b1, 8'h32, 16'h0013, 1'b0, 1'b0, 1'b0, 1'b0},
    '{1'b1, 8'h32, 16'h0013, 1'b1, 1'b0, 1'b0, 1'b1}, '{1'b1, 8'h32, 16'h0000, 1'b1, 1'b0, 1'b0, 1'b0},
    '{1'b1, 8'h64, 16'h0000, 1'b1, 1'b0, 1'b0, 1'b1}, '{1'b1, 8'h64, 16'h0013, 1'b0, 1'b0, 1'b0, 1'b0},
    '{1'b0, 8'h00, 16'h0000, 1'b0, 1'b1, 1'b0, 1'b1}, '{1'b0, 8'h00, 16'h0000, 1'b0, 1'b0, 1'b1, 1'b1}};
  // speed rows, motor moving, band 30
  // mode 3 falls back to the feedback judgement
  mso_srow_t srows [11] = '{'{2'h0, 1'b0, 16'h0406, 16'h03E8, 16'h0000, 1'b1},
    '{2'h0, 1'b0, 16'h0407, 16'h03E8, 16'h0000, 1'b0}, '{2'h0, 1'b0, 16'h03CA, 16'h03E8, 16'h0000, 1'b1},
    '{2'h0, 1'b0, 16'h03C9, 16'h03E8, 16'h0000, 1'b0}, '{2'h1, 1'b0, 16'h0000, 16'h03E8, 16'h03E8, 1'b1},
    '{2'h1, 1'b0, 16'h0000, 16'h03E7, 16'h03E8, 1'b0}, '{2'h2, 1'b0, 16'h07EE, 16'h07D0, 16'h07D0, 1'b1},
    '{2'h2, 1'b0, 16'h07EF, 16'h07D0, 16'h07D0, 1'b0}, '{2'h1, 1'b1, 16'h0000, 16'h03E8, 16'h03E8, 1'b0},
    '{2'h3, 1'b0, 16'h0406, 16'h03E8, 16'h0000, 1'b1}, '{2'h3, 1'b0, 16'h0000, 16'h03E8, 16'h03E8, 1'b0}};
  // clock generation
  always #2.5 clock = ~clock;
  // host start merged onto the start gate
  always_comb begin
    rdy_in = rdy_tb;
    rdy_in.start_any = rdy_tb.start_any | host_start;
  end
  mso_top u_mso_top (.clock(clock), .nrst(nrst), .rdy_in(rdy_in), .cfg(cfg), .mot(mot),
    .ready(ready), .move_active(move_active), .profile_busy(profile_busy),
    .in_position(in_position), .cutback_reached(cutback_reached),
    .torque_limit_reached(torque_limit_reached), .speed_attained(speed_attained));
  mso_host u_mso_host (.clock(clock), .nrst(nrst), .ready(ready), .go(go), .start(host_start));
  // ==========
  // reporting
  task automatic chk(input logic got, input logic exp, input string what);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: %s got %b want %b", $time, what, got, exp);
    end
  endtask
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask
  task automatic summarize();
    $display("tests %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      summarize();
    end
  end
  // ==========
  // main sequence
  initial begin
    rdy_tb = RDY_BASE;
    cfg = '{MOVE_MIN_DEF, INPOS_RANGE_DEF, INPOS_OFS_DEF, 1'b1, 8'h00, 2'h0, VA_BAND_DEF};
    mot = '0;
    mot.internal_profile = 1'b1;
    go = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    chk(ready | profile_busy | move_active, 1'b0, "outputs in reset");
    @(posedge clock);
    nrst <= 1'b1;
    mot.internal_profile <= 1'b0;
    $display("test reset done");
    foreach (rrows[i]) begin
      @(posedge clock);
      rdy_tb <= RDY_BASE ^ rrows[i].mask;
      settle();
      chk(ready, rrows[i].exp, "ready row");
    end
    @(posedge clock);
    rdy_tb <= RDY_BASE;
    go <= 1'b1;
    settle();
    chk(ready, 1'b0, "ready with host start");
    @(posedge clock);
    go <= 1'b0;
    settle();
    chk(ready, 1'b1, "ready after start");
    $display("test ready done");
    @(posedge clock);
    mot.motor_moving <= 1'b1;
    mot.internal_profile <= 1'b1;
    settle();
    chk(ready, 1'b0, "ready while moving");
    chk(move_active, 1'b1, "move");
    chk(profile_busy, 1'b1, "busy");
    foreach (srows[i]) begin
      @(posedge clock);
      cfg.va_mode <= srows[i].mode;
      mot.pulse_input_op <= srows[i].pulse;
      mot.detected_speed <= srows[i].det;
      mot.command_speed <= srows[i].cmd;
      mot.target_speed <= srows[i].tgt;
      settle();
      chk(speed_attained, srows[i].exp, "speed row");
    end
    foreach (trows[i]) begin
      @(posedge clock);
      mot.current_mode_select <= trows[i].sel;
      cfg.sve_ratio <= trows[i].ratio;
      mot.pos_deviation <= trows[i].dev;
      mot.current_at_limit <= trows[i].lim;
      mot.torque_over_rating <= trows[i].ovr;
      mot.push_motion <= trows[i].push;
      mot.push_torque_reached <= trows[i].push;
      settle();
      chk(torque_limit_reached, trows[i].exp, "torque row");
    end
    @(posedge clock);
    mot.motor_moving <= 1'b0;
    mot.internal_profile <= 1'b0;
    settle();
    chk(move_active, 1'b0, "move released");
    chk(speed_attained | profile_busy, 1'b0, "idle speed and busy");
    $display("test motion done");
    @(posedge clock);
    cfg.inpos_offset <= 8'hEE;
    mot.positioning_done <= 1'b1;
    mot.pos_deviation <= 16'hFFDB;
    settle();
    chk(in_position, 1'b0, "just outside window");
    @(posedge clock);
    mot.pos_deviation <= 16'hFFDC;
    settle();
    chk(in_position, 1'b1, "window edge");
    @(posedge clock);
    mot.motor_moving <= 1'b1;
    settle();
    chk(in_position, 1'b0, "moving again");
    @(posedge clock);
    mot.motor_moving <= 1'b0;
    mot.stop_interrupted <= 1'b1;
    settle();
    chk(in_position, 1'b0, "stop interrupted");
    @(posedge clock);
    mot.stop_interrupted <= 1'b0;
    mot.continuous_stop <= 1'b1;
    settle();
    chk(in_position, 1'b0, "continuous stop");
    $display("test in position done");
    @(posedge clock);
    cfg.cutback_enable <= 1'b0;
    mot.cutback_active <= 1'b1;
    mot.current_at_standstill <= 1'b1;
    settle();
    chk(cutback_reached, 1'b0, "cutback disabled");
    @(posedge clock);
    cfg.cutback_enable <= 1'b1;
    settle();
    chk(cutback_reached, 1'b1, "cutback enabled");
    $display("test cutback done");
    @(posedge clock);
    cfg.move_min_ms <= 8'h01;
    mot.motor_moving <= 1'b1;
    settle();
    @(posedge clock);
    mot.motor_moving <= 1'b0;
    settle();
    chk(move_active, 1'b1, "move stretched");
    @(posedge clock);
    nrst <= 1'b0;
    settle();
    chk(move_active | cutback_reached, 1'b0, "second reset");
    // release again in mid-run: levels come back, the stretch does not
    @(posedge clock);
    nrst <= 1'b1;
    settle();
    chk(cutback_reached, 1'b1, "cutback after reset");
    chk(move_active, 1'b0, "move after reset");
    chk(ready, 1'b1, "ready after reset");
    $display("test stretch done");
    summarize();
  end
endmodule
